// ---- hw/dual_buck_seq.sv ----
// Sequencing and protection supervisor for two buck channels and two regulators.
// Assumes comparator results arrive asynchronously and an AHB-Lite master on clk.
`timescale 1ns/1ps
`include "dual_buck_map.svh"
module dual_buck_seq
  import dual_buck_pkg::*;
#(
  parameter int unsigned PG_DELAY = `PG_DELAY_DEF,
  parameter int unsigned SS_CYC = `SS_CYCLES,
  parameter int unsigned BLANK_CYC = `BLANK_CYCLES,
  parameter int unsigned UV_CYC = `UV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_ch5v,
  input wire logic enable_ch3v,
  input wire chan_cmp_s cmp5,
  input wire chan_cmp_s cmp3,
  input wire logic supplyOk,
  input wire logic ldo5vOk,
  input wire logic ldo3v3Ok,
  input wire logic ldo3v3Above2v4,
  input wire logic out5vAboveLdoMinus1,
  input wire logic overTemp,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output gate_s gate5,
  output gate_s gate3,
  output logic [7:0] ref5,
  output logic [7:0] ref3,
  output logic power_good_out_oe_n,
  output logic charge_pump_clock,
  output logic ldo5vOn,
  output logic ldo3v3On,
  output logic switchover,
  output logic ldo3v3FromOut5v
);

  // Two-stage synchronisers for every enable, comparator and status level
  localparam int NSYNC = 24;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  assign rawIn = {enable_ch5v, enable_ch3v, cmp5, cmp3, supplyOk, ldo5vOk, ldo3v3Ok,
    ldo3v3Above2v4, out5vAboveLdoMinus1, overTemp};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
    end
  end
  logic [1:0] en;
  chan_cmp_s c [2];
  logic supOk, l5Ok, l3Ok, l3Above, o5Above, hot;
  assign en = {sync2_ff[22], sync2_ff[23]}; // Bit 0 is the 5 V channel, like c[0]
  assign c[0] = sync2_ff[21:14];
  assign c[1] = sync2_ff[13:6];
  assign {supOk, l5Ok, l3Ok, l3Above, o5Above, hot} = sync2_ff[5:0];

  // Register bus state: control word and captured address phase
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic wrPend_ff, nxt_wrPend;
  logic [7:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic alwaysOn;
  logic [31:0] statusWord;
  assign alwaysOn = ctrl_ff[`CTRL_ALWAYS_ON_BIT];

  // Global shutdown: lockout and over-temperature act without latching
  logic lockout;
  logic anyUvp;
  assign lockout = !supOk || !l5Ok || !l3Ok || hot;

  // Per-channel state machines
  chan_state_e st_ff [2];
  chan_state_e nxt_st [2];
  logic [15:0] ssCnt_ff [2];
  logic [15:0] nxt_ssCnt [2];
  logic [15:0] blankCnt_ff [2];
  logic [15:0] nxt_blankCnt [2];
  logic [12:0] uvCnt_ff [2];
  logic [12:0] nxt_uvCnt [2];
  logic [1:0] enPrev_ff, nxt_enPrev;
  logic [1:0] ovpPulse_ff, nxt_ovpPulse;
  logic [1:0] ovpLatched_ff, nxt_ovpLatched;
  logic [7:0] ref_ff [2];
  logic [7:0] nxt_ref [2];
  gate_s gate_ff [2];
  gate_s nxt_gate [2];
  logic [1:0] uvHit;
  assign anyUvp = (st_ff[0] == CH_UVP) || (st_ff[1] == CH_UVP);
  assign nxt_enPrev = en;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign uvHit[gi] = (uvCnt_ff[gi] >= 13'(UV_CYC - 1)) && c[gi].fbBelowUv;
      always_comb begin
        nxt_st[gi] = st_ff[gi];
        nxt_ssCnt[gi] = ssCnt_ff[gi];
        nxt_blankCnt[gi] = blankCnt_ff[gi];
        nxt_uvCnt[gi] = '0;
        nxt_ovpPulse[gi] = 1'b0;
        nxt_ovpLatched[gi] = ovpLatched_ff[gi];
        nxt_ref[gi] = ref_ff[gi];
        nxt_gate[gi] = '0;
        unique case (st_ff[gi])
          CH_OFF: begin
            nxt_ref[gi] = '0;
            nxt_gate[gi].discharge = 1'b1;
            nxt_ssCnt[gi] = '0;
            nxt_blankCnt[gi] = '0;
            nxt_ovpLatched[gi] = 1'b0;
            if (en[gi] && l5Ok && !lockout && !anyUvp) begin
              nxt_st[gi] = CH_SOFT;
              nxt_gate[gi].discharge = 1'b0;
            end
          end
          CH_SOFT, CH_RUN: begin
            // Reference ramps linearly; the whole count is scaled by REF_STEPS over SS_CYC
            if (ssCnt_ff[gi] < 16'(SS_CYC - 1)) begin
              nxt_ssCnt[gi] = ssCnt_ff[gi] + 16'h0001;
            end
            nxt_ref[gi] = 8'((32'(ssCnt_ff[gi]) * `REF_STEPS) / SS_CYC);
            if (ssCnt_ff[gi] >= 16'(SS_CYC - 1)) begin
              nxt_ref[gi] = 8'hff;
              nxt_st[gi] = CH_RUN;
            end
            if (blankCnt_ff[gi] < 16'(BLANK_CYC)) begin
              nxt_blankCnt[gi] = blankCnt_ff[gi] + 16'h0001;
            end
            if (c[gi].fbBelowUv && blankCnt_ff[gi] >= 16'(BLANK_CYC)) begin
              nxt_uvCnt[gi] = uvCnt_ff[gi] + 13'h0001;
            end
            // Valley limit: hold the high side off and the low side on while the trip holds
            nxt_gate[gi].highSide = !c[gi].ocTrip;
            nxt_gate[gi].lowSide = c[gi].ocTrip;
            if (!en[gi] || lockout) begin
              nxt_st[gi] = CH_OFF;
            end else if (anyUvp) begin
              nxt_st[gi] = CH_UVP;
            end else if (uvHit[gi] && blankCnt_ff[gi] >= 16'(BLANK_CYC)) begin
              nxt_st[gi] = CH_UVP;
            end else if (c[gi].fbAbove115) begin
              nxt_st[gi] = CH_OVP;
            end
          end
          CH_OVP: begin
            nxt_ref[gi] = '0;
            nxt_gate[gi].lowSide = 1'b1;
            if (c[gi].fbAtZero || ovpLatched_ff[gi]) begin
              nxt_ovpLatched[gi] = 1'b1;
            end else if (ovpPulse_ff[gi] || (c[gi].negLimit && !gate_ff[gi].highSide)) begin
              // One on-time pulse, then back to the low side
              nxt_gate[gi].highSide = !c[gi].onTimeDone;
              nxt_gate[gi].lowSide = c[gi].onTimeDone;
              nxt_ovpPulse[gi] = !c[gi].onTimeDone;
            end
            if (!en[gi]) begin
              nxt_st[gi] = CH_OFF;
            end
          end
          CH_UVP: begin
            nxt_ref[gi] = '0;
            nxt_gate[gi].discharge = 1'b1;
            if (!en[gi] && enPrev_ff[gi]) begin
              nxt_st[gi] = CH_OFF;
            end
          end
        endcase
        if (hot) begin
          nxt_gate[gi].highSide = 1'b0;
          nxt_gate[gi].lowSide = 1'b0;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_ff[gi] <= CH_OFF;
          ssCnt_ff[gi] <= '0;
          blankCnt_ff[gi] <= '0;
          uvCnt_ff[gi] <= '0;
          ref_ff[gi] <= '0;
          gate_ff[gi] <= '0;
          ovpPulse_ff[gi] <= 1'b0;
          ovpLatched_ff[gi] <= 1'b0;
          enPrev_ff[gi] <= 1'b0;
        end else begin
          st_ff[gi] <= nxt_st[gi];
          ssCnt_ff[gi] <= nxt_ssCnt[gi];
          blankCnt_ff[gi] <= nxt_blankCnt[gi];
          uvCnt_ff[gi] <= nxt_uvCnt[gi];
          ref_ff[gi] <= nxt_ref[gi];
          gate_ff[gi] <= nxt_gate[gi];
          ovpPulse_ff[gi] <= nxt_ovpPulse[gi];
          ovpLatched_ff[gi] <= nxt_ovpLatched[gi];
          enPrev_ff[gi] <= nxt_enPrev[gi];
        end
      end
    end
  endgenerate

  // Power-good, clock, regulators and switchover
  logic [15:0] pgCnt_ff, nxt_pgCnt;
  logic pg_ff, nxt_pg;
  logic [5:0] cpCnt_ff, nxt_cpCnt;
  logic cp_ff, nxt_cp;
  logic l5_ff, nxt_l5, l3_ff, nxt_l3, sw_ff, nxt_sw;
  logic pgQual;
  assign pgQual = en[0] && en[1] && (st_ff[0] == CH_RUN) && (st_ff[1] == CH_RUN)
    && c[0].fbAbove90 && c[1].fbAbove90 && !c[0].fbAbove115 && !c[1].fbAbove115
    && !c[0].fbBelow60 && !c[1].fbBelow60;
  always_comb begin
    nxt_pgCnt = '0;
    nxt_pg = 1'b0;
    if (pgQual) begin
      nxt_pgCnt = (pgCnt_ff < 16'(PG_DELAY)) ? pgCnt_ff + 16'h0001 : pgCnt_ff;
      nxt_pg = pg_ff || (pgCnt_ff >= 16'(PG_DELAY));
    end
    // Clock divider only runs with the 5 V enable and no over-temperature; cleared low otherwise
    nxt_cpCnt = '0;
    nxt_cp = 1'b0;
    if (en[0] && !hot) begin
      nxt_cp = cp_ff;
      nxt_cpCnt = cpCnt_ff + 6'h01;
      if (cpCnt_ff >= 6'(`CP_HALF_CYCLES - 1)) begin
        nxt_cpCnt = '0;
        nxt_cp = !cp_ff;
      end
    end
    nxt_l3 = !hot;
    nxt_l5 = !hot && l3Above && (alwaysOn || en[0] || en[1]);
    nxt_sw = en[0] && (st_ff[0] == CH_RUN) && !c[0].ocTrip && o5Above && !hot;
    if (nxt_sw) begin
      nxt_l5 = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pgCnt_ff <= '0;
      pg_ff <= 1'b0;
      cpCnt_ff <= '0;
      cp_ff <= 1'b0;
      l5_ff <= 1'b0;
      l3_ff <= 1'b0;
      sw_ff <= 1'b0;
    end else begin
      pgCnt_ff <= nxt_pgCnt;
      pg_ff <= nxt_pg;
      cpCnt_ff <= nxt_cpCnt;
      cp_ff <= nxt_cp;
      l5_ff <= nxt_l5;
      l3_ff <= nxt_l3;
      sw_ff <= nxt_sw;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign statusWord = {16'h0000, 3'b000, st_ff[1], st_ff[0], pg_ff, sw_ff, cp_ff};
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_wrPend = 1'b0;
    nxt_addr = addr_ff;
    nxt_rdata = 32'h0000_0000;
    if (wrPend_ff && addr_ff == `ADDR_CTRL) begin
      nxt_ctrl = {31'h0, hwdata[`CTRL_ALWAYS_ON_BIT]};
    end
    if (hsel && hready && htrans[1]) begin
      nxt_addr = haddr;
      nxt_wrPend = hwrite;
      if (!hwrite) begin
        unique case (haddr)
          `ADDR_CTRL: nxt_rdata = ctrl_ff;
          `ADDR_STATUS: nxt_rdata = statusWord;
          `ADDR_REFS: nxt_rdata = {16'h0000, ref_ff[1], ref_ff[0]};
          default: nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET_VAL;
      wrPend_ff <= 1'b0;
      addr_ff <= '0;
      rdata_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      wrPend_ff <= nxt_wrPend;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flip-flops or constants; open-drain enable low pulls the pin
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign gate5 = gate_ff[0];
  assign gate3 = gate_ff[1];
  assign ref5 = ref_ff[0];
  assign ref3 = ref_ff[1];
  assign power_good_out_oe_n = pg_ff;
  assign charge_pump_clock = cp_ff;
  assign ldo5vOn = l5_ff;
  assign ldo3v3On = l3_ff;
  assign switchover = sw_ff;
  assign ldo3v3FromOut5v = sw_ff;

  // Checks: each guard but a_sw_ldo_off and a_ovp_latch looks one edge after its cause, so register lag is allowed
  a_clk_gated: assert property (@(posedge clk) disable iff (rst)
    !en[0] |=> !charge_pump_clock) else $error("pump clock ran with 5 V enable off");
  a_pg_low_uvp: assert property (@(posedge clk) disable iff (rst)
    anyUvp |=> !pg_ff) else $error("power good high during undervoltage");
  a_pg_ov: assert property (@(posedge clk) disable iff (rst)
    c[0].fbAbove115 || c[1].fbAbove115 |=> !pg_ff)
    else $error("power good high during overvoltage");
  a_pg_uv60: assert property (@(posedge clk) disable iff (rst)
    c[0].fbBelow60 || c[1].fbBelow60 |=> !pg_ff)
    else $error("power good high below 60 percent");
  a_uvp_gates: assert property (@(posedge clk) disable iff (rst)
    st_ff[0] == CH_UVP |=> !gate_ff[0].highSide && !gate_ff[0].lowSide)
    else $error("gates on during undervoltage latch");
  a_uvp_discharge: assert property (@(posedge clk) disable iff (rst)
    st_ff[1] == CH_UVP |=> gate_ff[1].discharge)
    else $error("no discharge during undervoltage latch");
  a_sw_ldo_off: assert property (@(posedge clk) disable iff (rst)
    sw_ff |-> !l5_ff) else $error("5 V regulator on during switchover");
  a_hot_ldo: assert property (@(posedge clk) disable iff (rst)
    hot |=> !l3_ff && !l5_ff) else $error("regulators on while hot");
  a_ovp_target: assert property (@(posedge clk) disable iff (rst)
    st_ff[1] == CH_OVP |=> ref_ff[1] == 8'h00) else $error("target not zero in overvoltage");

  // Ramp always starts from a zero reference, so outputs never jump at enable
  a_ref_off_zero: assert property (@(posedge clk) disable iff (rst)
    st_ff[0] == CH_OFF |=> ref_ff[0] == 8'h00)
    else $error("reference not zero while channel off");
  // A trip in soft-start or run must block the next high-side pulse
  a_valley_hold: assert property (@(posedge clk) disable iff (rst)
    (st_ff[0] == CH_SOFT || st_ff[0] == CH_RUN) && c[0].ocTrip |=> !gate_ff[0].highSide)
    else $error("high side pulsed above the trip level");
  // Switchover drops as soon as any of these three of its five conditions fails
  a_sw_needs_run: assert property (@(posedge clk) disable iff (rst)
    (st_ff[0] != CH_RUN) || c[0].ocTrip || !o5Above |=> !sw_ff)
    else $error("switchover held without its conditions");
  // Lockout is not latched, but it must stop both ramps at once
  a_lockout_stop: assert property (@(posedge clk) disable iff (rst)
    lockout |=> (st_ff[0] != CH_SOFT) && (st_ff[0] != CH_RUN)
      && (st_ff[1] != CH_SOFT) && (st_ff[1] != CH_RUN))
    else $error("channel kept switching during lockout");
  // One channel's undervoltage latch pulls the other down with it
  a_uvp_spread: assert property (@(posedge clk) disable iff (rst)
    (st_ff[0] == CH_UVP) && (st_ff[1] == CH_RUN) && en[1] && !lockout |=> st_ff[1] == CH_UVP)
    else $error("undervoltage latch did not spread to both channels");

  // Multi-step behaviours are described by named sequences
  sequence s_ramp_start;
    (st_ff[0] == CH_OFF) ##1 (st_ff[0] == CH_SOFT);
  endsequence : s_ramp_start
  sequence s_ovp_held;
    (st_ff[1] == CH_OVP) && ovpLatched_ff[1];
  endsequence : s_ovp_held
  // Blanking covers at least the first eight cycles of any ramp
  a_uv_blanked: assert property (@(posedge clk) disable iff (rst)
    s_ramp_start |=> (uvCnt_ff[0] == 13'h0000) [*8])
    else $error("undervoltage counted inside the start-up blanking");
  // After the zero crossing only the low side may drive, unless heat forced both off
  a_ovp_latch: assert property (@(posedge clk) disable iff (rst)
    s_ovp_held |-> !gate_ff[1].highSide && (gate_ff[1].lowSide || $past(hot)))
    else $error("gate drive not latched to low side after overvoltage");
endmodule : dual_buck_seq

// ---- include/dual_buck_map.svh ----
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef DUAL_BUCK_MAP_SVH
`define DUAL_BUCK_MAP_SVH
`define CLK_HZ 20000000
`define SS_TIME_NS 800000
`define SS_CYCLES (`SS_TIME_NS / 50)
`define UV_TIME_NS 250000
`define UV_CYCLES (`UV_TIME_NS / 50)
`define BLANK_TIME_NS 1100000
`define BLANK_CYCLES (`BLANK_TIME_NS / 50)
`define CP_HZ 256000
`define CP_HALF_CYCLES (`CLK_HZ / (2 * `CP_HZ))
`define PG_DELAY_DEF 1000
`define REF_STEPS 255
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_REFS 8'h08
`define CTRL_ALWAYS_ON_BIT 0
`define CTRL_RESET_VAL 32'h0000_0000
`endif

// ---- include/dual_buck_pkg.sv ----
// Types shared by the sequencer design.
// Assumes the map header supplies all numeric constants.
package dual_buck_pkg;
  typedef enum logic [4:0] {
    CH_OFF = 5'b00001,
    CH_SOFT = 5'b00010,
    CH_RUN = 5'b00100,
    CH_OVP = 5'b01000,
    CH_UVP = 5'b10000
  } chan_state_e;
  typedef struct packed {
    logic fbAbove90;
    logic fbAbove115;
    logic fbBelow60;
    logic fbBelowUv;
    logic fbAtZero;
    logic ocTrip;
    logic negLimit;
    logic onTimeDone;
  } chan_cmp_s;
  typedef struct packed {
    logic highSide;
    logic lowSide;
    logic discharge;
  } gate_s;
endpackage : dual_buck_pkg

// ---- tb/power_stage_model.sv ----
// Power stage and feedback divider of one buck channel, seen as comparator levels.
// Assumes gate and reference codes from the sequencer on clk; commands come from the bench.
`timescale 1ns/1ps
module power_stage_model
  import dual_buck_pkg::*;
(
  input wire logic clk,
  input wire gate_s gate,
  input wire logic [7:0] refCode,
  input wire logic ovCmd,
  input wire logic ocCmd,
  input wire logic sagCmd,
  output chan_cmp_s cmp
);
  logic [7:0] level = 8'h00;
  // Output tracks the reference; a sag or the discharge path drags it to zero
  always @(posedge clk) begin
    if (sagCmd || gate.discharge) level <= 8'h00;
    else level <= refCode;
  end
  // Thresholds scaled to the 255 = 2 V code; undervoltage shares the 60 percent level
  always_comb begin
    cmp.fbAbove90 = level >= 8'he6;
    cmp.fbAbove115 = ovCmd;
    cmp.fbBelow60 = level < 8'h99;
    cmp.fbBelowUv = level < 8'h99;
    cmp.fbAtZero = level == 8'h00;
    cmp.ocTrip = ocCmd;
    cmp.negLimit = gate.lowSide; // Crude: low side always reaches the negative limit
    cmp.onTimeDone = gate.highSide;
  end
endmodule : power_stage_model

// ---- tb/test_dual_buck_sequencing_protection.sv ----
// Self-checking bench of the sequencer with two power stage models.
// Assumes short counts: soft-start 64, blanking 80, undervoltage 10, power-good 5.
`timescale 1ns/1ps
`include "dual_buck_map.svh"
module test_dual_buck_sequencing_protection
  import dual_buck_pkg::*;
;
  logic clk = 0, rst = 1, en5 = 0, en3 = 0, supplyOk = 1, ldo5vOk = 1, ldo3v3Ok = 1;
  logic above2v4 = 1, out5vAbove = 1, overTemp = 0, hsel = 0, hwrite = 0;
  logic ov5 = 0, ov3 = 0, oc5 = 0, oc3 = 0, sag5 = 0, sag3 = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, rd, seed = 32'h35311c88;
  logic [31:0] hrdata;
  logic [7:0] ref5, ref3;
  logic hreadyout, hresp, pgOeN, cpClk, ldo5vOn, ldo3v3On, switchover, ldo3v3FromOut5v;
  chan_cmp_s cmp5, cmp3;
  gate_s gate5, gate3;
  int num_errors = 0, n_tests = 0, cycles = 0, hi;

  always #25 clk = ~clk;

  dual_buck_seq #(.PG_DELAY(5), .SS_CYC(64), .BLANK_CYC(80), .UV_CYC(10)) DUT (
    .clk(clk), .rst(rst), .enable_ch5v(en5), .enable_ch3v(en3), .cmp5(cmp5), .cmp3(cmp3),
    .supplyOk(supplyOk), .ldo5vOk(ldo5vOk), .ldo3v3Ok(ldo3v3Ok), .ldo3v3Above2v4(above2v4),
    .out5vAboveLdoMinus1(out5vAbove), .overTemp(overTemp), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gate5(gate5), .gate3(gate3),
    .ref5(ref5), .ref3(ref3), .power_good_out_oe_n(pgOeN), .charge_pump_clock(cpClk),
    .ldo5vOn(ldo5vOn), .ldo3v3On(ldo3v3On), .switchover(switchover),
    .ldo3v3FromOut5v(ldo3v3FromOut5v));
  power_stage_model stage5 (.clk(clk), .gate(gate5), .refCode(ref5), .ovCmd(ov5),
    .ocCmd(oc5), .sagCmd(sag5), .cmp(cmp5));
  power_stage_model stage3 (.clk(clk), .gate(gate3), .refCode(ref3), .ovCmd(ov3),
    .ocCmd(oc3), .sagCmd(sag3), .cmp(cmp3));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Sample a settled point just after an edge
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : run

  // Single word transfer; each phase holds until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++w < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++w < 50);
    rd = hrdata;
    if (w >= 50) num_errors++;
  endtask : bus

  task automatic done(input string name);
    $display("%s finished, %0d checks so far", name, n_tests);
  endtask : done

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Hang guard well above the roughly 1800 cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    run(1);
    check("power_good_out after reset", pgOeN, 0);
    check("pump after reset", cpClk, 0);
    bus(0, `ADDR_CTRL, 0);
    check("ctrl reset", rd, `CTRL_RESET_VAL);
    check("hresp okay", hresp, 0);
    // Random words with the variant bit walked through both values
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      bus(1, `ADDR_CTRL, {seed[31:1], i[0]});
      bus(0, `ADDR_CTRL, 0);
      check("ctrl variant", rd[0], i[0]);
      run(6);
      check("ldo5 both off", ldo5vOn, i[0]);
    end
    @(posedge clk) above2v4 <= 1'b0;
    run(6);
    check("ldo5 below 2v4", ldo5vOn, 0);
    @(posedge clk) above2v4 <= 1'b1;
    bus(0, 8'h0c, 0);
    check("unmapped read", rd, 0);
    done("registers");
    @(posedge clk) en5 <= 1'b1;
    run(120);
    check("ref5 ramp", ref5, 8'hff);
    check("ref3 idle", ref3, 0);
    bus(0, `ADDR_STATUS, 0);
    check("ch5 run", rd[7:3], 5'b00100);
    check("power_good_out one ch", pgOeN, 0);
    @(posedge cpClk);
    hi = 0;
    while (cpClk === 1'b1) begin
      run(1);
      hi++;
    end
    check("pump half", hi, `CP_HALF_CYCLES);
    check("switchover", switchover, 1);
    check("ldo3 from out5", ldo3v3FromOut5v, 1);
    check("ldo5 off in switchover", ldo5vOn, 0);
    @(posedge clk) oc5 <= 1'b1;
    run(6);
    check("switchover oc", switchover, 0);
    check("hs blocked oc", gate5.highSide, 0);
    @(posedge clk) oc5 <= 1'b0;
    out5vAbove <= 1'b0;
    run(6);
    check("switchover low out", switchover, 0);
    @(posedge clk) out5vAbove <= 1'b1;
    done("channel 5v");
    @(posedge clk) en3 <= 1'b1;
    run(140);
    check("power_good_out both", pgOeN, 1);
    @(posedge clk) ov3 <= 1'b1;
    run(6);
    check("power_good_out ov", pgOeN, 0);
    run(100);
    check("ov target", ref3, 0);
    check("ov latch", {gate3.highSide, gate3.lowSide}, 2'b01);
    @(posedge clk) ov3 <= 1'b0;
    en3 <= 1'b0;
    run(10);
    check("ch3 discharge", gate3.discharge, 1);
    @(posedge clk) en3 <= 1'b1;
    run(140);
    check("ov cleared", ref3, 8'hff);
    @(posedge clk) en5 <= 1'b0;
    run(10);
    check("ch5 discharge", gate5.discharge, 1);
    hi = 0;
    repeat (100) begin
      run(1);
      if (cpClk !== 1'b0) hi++;
    end
    check("pump stopped", hi, 0);
    @(posedge clk) en5 <= 1'b1;
    run(140);
    done("overvoltage");
    @(posedge clk) sag5 <= 1'b1;
    run(6);
    check("power_good_out sag", pgOeN, 0);
    run(40);
    check("uv gates ch5", {gate5.highSide, gate5.lowSide, gate5.discharge}, 3'b001);
    check("uv gates ch3", {gate3.highSide, gate3.lowSide, gate3.discharge}, 3'b001);
    @(posedge clk) sag5 <= 1'b0;
    run(20);
    bus(0, `ADDR_STATUS, 0);
    check("uv latched", rd[7:3], 5'b10000);
    @(posedge clk) en5 <= 1'b0;
    en3 <= 1'b0;
    run(10);
    @(posedge clk) en5 <= 1'b1;
    en3 <= 1'b1;
    run(140);
    check("uv cleared", ref5, 8'hff);
    done("undervoltage");
    // Each of the three OK-flag lockout sources alone stops both channels, then recovery is unlatched
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) {supplyOk, ldo5vOk, ldo3v3Ok} <= ~(3'b100 >> i);
      run(8);
      bus(0, `ADDR_STATUS, 0);
      check("lockout states", {rd[12:8], rd[7:3]}, 10'h021);
      @(posedge clk) {supplyOk, ldo5vOk, ldo3v3Ok} <= 3'b111;
      run(140);
      check("lockout resume", ref5, 8'hff);
    end
    @(posedge clk) overTemp <= 1'b1;
    run(8);
    check("hot ldos", {ldo5vOn, ldo3v3On}, 2'b00);
    check("hot gates", gate5.highSide | gate3.highSide, 0);
    @(posedge clk) overTemp <= 1'b0;
    run(140);
    check("cool ldo3", ldo3v3On, 1);
    check("cool ref3", ref3, 8'hff);
    done("lockout and thermal");
    stop_test();
  end
endmodule : test_dual_buck_sequencing_protection
